// [rtl/glt_controller.sv]
// Teach-in, indication and safety output control of a guard locking switch.
// Assumes synchronous inputs, an external non-volatile store that presents
// its image at power-up and accepts a whole image on each write pulse.
`timescale 1ns/1ps
module glt_controller #(
    parameter int unsigned P_TICK_CYCLES = glt_pkg::TICK_CYCLES
) (
    input  wire logic                  i_clock,
    input  wire logic                  i_arst_n,
    input  wire logic                  i_variant_unique,
    input  wire logic                  i_guard_closed,
    input  wire glt_pkg::glt_actuator_t i_actuator,
    input  wire logic                  i_lock_command,
    input  wire logic                  i_cascade_inputs_on,
    input  wire logic                  i_internal_fault,
    input  wire glt_pkg::glt_nv_t      i_nv_image,
    output logic [1:0]                 o_safety_output_pair,
    output logic                       o_lock_engage,
    output logic                       o_status_green,
    output logic                       o_fault_indicator_red,
    output logic                       o_nv_write,
    output glt_pkg::glt_nv_t           o_nv_image
);

    localparam int unsigned ID_W_C = glt_pkg::ID_W;

    glt_pkg::glt_state_t state;
    glt_pkg::glt_state_t next_state;
    glt_pkg::glt_fault_t fault_code;
    glt_pkg::glt_fault_t next_fault;
    glt_pkg::glt_nv_t    nv;
    logic                loaded;
    logic [24:0]         tick_cnt;
    logic                tick;
    logic [1:0]          slow_div;
    logic [4:0]          slow_slot;
    logic [4:0]          fast_slot;
    logic [6:0]          phase_ticks;
    logic                phase_clear;
    logic                phase_done;
    logic [ID_W_C-1:0]   teach_id;
    logic                current_match;
    logic                valid_actuator;
    logic [1:0]          next_outputs;
    logic                next_green;
    logic                next_red;

    // Flash n times within a frame, pause for the rest
    function automatic logic burst(input logic [4:0] slot, input logic [3:0] n);
        return (slot < {n, 1'b0}) && !slot[0];
    endfunction

    // Refusal code for an actuator offered for teach-in, checked in priority
    function automatic glt_pkg::glt_fault_t offer_check(input glt_pkg::glt_nv_t img,
                                                        input glt_pkg::glt_actuator_t act);
        logic seen;
        seen = 1'b0;
        for (int i = 0; i < 8; i++) begin
            if (4'(i) < img.count && img.ids[i] == act.id) begin
                seen = 1'b1;
            end
        end
        if (img.permanent) begin
            return glt_pkg::FLT_PERM;
        end else if (img.count >= glt_pkg::MAX_TAUGHT) begin
            return glt_pkg::FLT_FULL;
        end else if (act.universal) begin
            return glt_pkg::FLT_UNIVERSAL;
        end else if (seen) begin
            return glt_pkg::FLT_TAUGHT;
        end
        return glt_pkg::FLT_NONE;
    endfunction

    // ---------------------------------------------------------------
    // Timebase
    // ---------------------------------------------------------------
    assign tick = (tick_cnt == 25'(P_TICK_CYCLES - 1));

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            tick_cnt <= 25'h0000000;
        end else if (tick) begin
            tick_cnt <= 25'h0000000;
        end else begin
            tick_cnt <= tick_cnt + 25'h0000001;
        end
    end

    // Slot counters restart with every state change except ST_COMPLETE into ST_PERM_ACK, so each pattern starts clean
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            slow_div  <= 2'h0;
            slow_slot <= 5'h00;
            fast_slot <= 5'h00;
        end else if (phase_clear) begin
            slow_div  <= 2'h0;
            slow_slot <= 5'h00;
            fast_slot <= 5'h00;
        end else if (tick) begin
            slow_div  <= slow_div + 2'h1;
            fast_slot <= (fast_slot == 5'(glt_pkg::FAST_FRAME - 1)) ? 5'h00 : fast_slot + 5'h01;
            if (slow_div == 2'(glt_pkg::SLOW_HALF_TICKS - 1)) begin
                slow_slot <= (slow_slot == 5'(glt_pkg::SLOW_FRAME - 1)) ? 5'h00
                                                                       : slow_slot + 5'h01;
            end
        end
    end

    // Window keeps running from programming-complete into the acknowledge
    assign phase_clear = (next_state != state) &&
                         !(state == glt_pkg::ST_COMPLETE && next_state == glt_pkg::ST_PERM_ACK);
    assign phase_done  = tick && (phase_ticks == 7'(glt_pkg::PHASE_TICKS - 1));

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            phase_ticks <= 7'h00;
        end else if (phase_clear) begin
            phase_ticks <= 7'h00;
        end else if (tick && phase_ticks != 7'h7F) begin
            phase_ticks <= phase_ticks + 7'h01;
        end
    end

    // ---------------------------------------------------------------
    // Sequence
    // ---------------------------------------------------------------
    assign current_match  = (nv.count != 4'h0) && i_actuator.present &&
                            (i_actuator.id == nv.ids[3'(nv.count - 4'h1)]);
    assign valid_actuator = i_variant_unique ? current_match
                                             : i_actuator.present;

    always_comb begin
        next_state = state;
        next_fault = fault_code;
        unique case (state)
            glt_pkg::ST_INIT: begin
                if (loaded && tick && phase_ticks == 7'(glt_pkg::INIT_TICKS - 1)) begin
                    next_state = (i_variant_unique && nv.count == 4'h0) ? glt_pkg::ST_AWAIT
                                                                         : glt_pkg::ST_RUN;
                end
            end
            glt_pkg::ST_AWAIT, glt_pkg::ST_PRESENT, glt_pkg::ST_RUN: begin
                if (state != glt_pkg::ST_RUN && i_actuator.present) begin
                    next_state = glt_pkg::ST_PRESENT;
                end else if (state == glt_pkg::ST_PRESENT) begin
                    next_state = glt_pkg::ST_AWAIT;
                end
                // Automatic start, no other trigger
                if (i_variant_unique && i_guard_closed && i_actuator.present && !current_match) begin
                    next_fault = offer_check(nv, i_actuator);
                    next_state = (next_fault == glt_pkg::FLT_NONE) ? glt_pkg::ST_VERIFY
                                                                    : glt_pkg::ST_FAULT;
                end
            end
            glt_pkg::ST_VERIFY, glt_pkg::ST_PROGRAM: begin
                if (!i_actuator.present) begin
                    next_fault = glt_pkg::FLT_RANGE;
                    next_state = glt_pkg::ST_FAULT;
                end else if (phase_done) begin
                    next_state = (state == glt_pkg::ST_VERIFY) ? glt_pkg::ST_PROGRAM
                                                               : glt_pkg::ST_COMPLETE;
                end
            end
            glt_pkg::ST_COMPLETE: begin
                if (!i_guard_closed) begin
                    next_state = glt_pkg::ST_PERM_ACK;
                end else if (phase_done) begin
                    next_state = glt_pkg::ST_RUN;
                end
            end
            glt_pkg::ST_PERM_ACK: begin
                if (phase_done) begin
                    next_state = glt_pkg::ST_RUN;
                end else if (i_guard_closed) begin
                    next_state = glt_pkg::ST_PERM_DONE;
                end
            end
            glt_pkg::ST_PERM_DONE: begin
                if (phase_done) begin
                    next_state = glt_pkg::ST_RUN;
                end
            end
            glt_pkg::ST_FAULT: begin
                next_state = glt_pkg::ST_FAULT;
            end
            default: begin
                next_state = glt_pkg::ST_FAULT;
            end
        endcase
    end

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state      <= glt_pkg::ST_INIT;
            fault_code <= glt_pkg::FLT_NONE;
        end else begin
            state      <= next_state;
            fault_code <= next_fault;
        end
    end

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            teach_id <= '0;
        end else if (next_state == glt_pkg::ST_VERIFY && state != glt_pkg::ST_VERIFY) begin
            teach_id <= i_actuator.id;
        end
    end

    // ---------------------------------------------------------------
    // Non-volatile image
    // ---------------------------------------------------------------
    // Image is captured after reset release, never under the reset itself
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            nv         <= '0;
            loaded     <= 1'b0;
            o_nv_write <= 1'b0;
        end else begin
            o_nv_write <= 1'b0;
            if (!loaded) begin
                nv     <= i_nv_image;
                loaded <= 1'b1;
            end else if (state == glt_pkg::ST_PROGRAM && next_state == glt_pkg::ST_COMPLETE) begin
                nv.ids[nv.count[2:0]] <= teach_id;
                nv.count              <= nv.count + 4'h1;
                o_nv_write            <= 1'b1;
            end else if (state == glt_pkg::ST_PERM_ACK && next_state == glt_pkg::ST_PERM_DONE &&
                         i_variant_unique) begin
                nv.permanent <= 1'b1;
                o_nv_write   <= 1'b1;
            end
        end
    end

    assign o_nv_image = nv;

    // ---------------------------------------------------------------
    // Indicators and outputs
    // ---------------------------------------------------------------
    always_comb begin
        next_outputs = 2'h0;
        next_green   = 1'b0;
        next_red     = 1'b0;
        unique case (state)
            glt_pkg::ST_INIT:     next_green = burst(slow_slot, glt_pkg::INIT_FLASHES);
            glt_pkg::ST_AWAIT:    next_green = burst(slow_slot, glt_pkg::AWAIT_FLASHES);
            glt_pkg::ST_PRESENT:  next_green = !slow_slot[0];
            glt_pkg::ST_VERIFY: begin
                next_green = !slow_slot[0];
                next_red   = !slow_slot[0];
            end
            glt_pkg::ST_PROGRAM: begin
                next_green = !fast_slot[0];
                next_red   = !fast_slot[0];
            end
            glt_pkg::ST_COMPLETE: begin
                next_green = burst(slow_slot, glt_pkg::MAX_TAUGHT - nv.count);
            end
            glt_pkg::ST_PERM_ACK:  next_red   = 1'b1;
            glt_pkg::ST_PERM_DONE: next_green = !slow_slot[0];
            glt_pkg::ST_FAULT: begin
                next_red   = burst(fast_slot, glt_pkg::FAULT_RED_FLASH);
                next_green = burst(fast_slot, {1'b0, fault_code});
            end
            glt_pkg::ST_RUN: begin
                if (i_internal_fault) begin
                    next_red = !fast_slot[0];
                end else if (!i_lock_command) begin
                    next_red = 1'b1;
                end else if (!valid_actuator || !i_guard_closed) begin
                    next_green = !fast_slot[0];
                end else if (!i_cascade_inputs_on) begin
                    next_green = !slow_slot[0];
                end else begin
                    next_green   = 1'b1;
                    next_outputs = 2'h3;
                end
            end
            default: begin
                next_red = 1'b1;
            end
        endcase
    end

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_safety_output_pair  <= 2'h0;
            o_lock_engage         <= 1'b0;
            o_status_green        <= 1'b0;
            o_fault_indicator_red <= 1'b0;
        end else begin
            o_safety_output_pair  <= next_outputs;
            o_lock_engage         <= (state == glt_pkg::ST_RUN) && i_lock_command;
            o_status_green        <= next_green;
            o_fault_indicator_red <= next_red;
        end
    end

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    property p_off_outside_run;
        @(posedge i_clock) disable iff (!i_arst_n)
        (state != glt_pkg::ST_RUN) |=> (o_safety_output_pair == 2'h0);
    endproperty
    a_off_outside_run: assert property (p_off_outside_run) else $error("outputs on");

    property p_count_limit;
        @(posedge i_clock) disable iff (!i_arst_n)
        loaded |-> (nv.count <= glt_pkg::MAX_TAUGHT);
    endproperty
    a_count_limit: assert property (p_count_limit) else $error("too many taught");

    property p_on_needs_current;
        @(posedge i_clock) disable iff (!i_arst_n)
        (next_outputs != 2'h0 && i_variant_unique) |-> current_match;
    endproperty
    a_on_needs_current: assert property (p_on_needs_current) else $error("stale actuator");

    property p_perm_refuses;
        @(posedge i_clock) disable iff (!i_arst_n)
        (nv.permanent && state == glt_pkg::ST_RUN) |=> (state != glt_pkg::ST_VERIFY);
    endproperty
    a_perm_refuses: assert property (p_perm_refuses) else $error("teach after coding");

    property p_perm_window;
        @(posedge i_clock) disable iff (!i_arst_n)
        $rose(nv.permanent) && loaded && $past(loaded) |-> $past(state == glt_pkg::ST_PERM_ACK);
    endproperty
    a_perm_window: assert property (p_perm_window) else $error("coding outside window");

    property p_ack_red;
        @(posedge i_clock) disable iff (!i_arst_n)
        (state == glt_pkg::ST_PERM_ACK) |=> o_fault_indicator_red;
    endproperty
    a_ack_red: assert property (p_ack_red) else $error("no red acknowledge");

    property p_lock_follows;
        @(posedge i_clock) disable iff (!i_arst_n)
        (state == glt_pkg::ST_RUN && i_lock_command) |=> o_lock_engage;
    endproperty
    a_lock_follows: assert property (p_lock_follows) else $error("lock not engaged");

    property p_fault_holds;
        @(posedge i_clock) disable iff (!i_arst_n)
        (state == glt_pkg::ST_FAULT) |=> (state == glt_pkg::ST_FAULT) && $stable(fault_code);
    endproperty
    a_fault_holds: assert property (p_fault_holds) else $error("fault cleared");

    property p_no_actuator_off;
        @(posedge i_clock) disable iff (!i_arst_n)
        (i_lock_command && !i_actuator.present) |=> (o_safety_output_pair == 2'h0);
    endproperty
    a_no_actuator_off: assert property (p_no_actuator_off) else $error("on without actuator");

    property p_verify_exit;
        @(posedge i_clock) disable iff (!i_arst_n)
        $fell(state == glt_pkg::ST_VERIFY) |->
            (state == glt_pkg::ST_PROGRAM || state == glt_pkg::ST_FAULT);
    endproperty
    a_verify_exit: assert property (p_verify_exit) else $error("bad phase order");

endmodule

// [rtl/glt_pkg.sv]
// Constants, states and carriers of the guard lock teach-in controller.
// Assumes a 250 MHz system clock and power-up acting as the only reset.
package glt_pkg;

    // ---------------------------------------------------------------
    // Timebase
    // ---------------------------------------------------------------
    localparam int unsigned CLK_HZ          = 250_000_000;
    localparam int unsigned TICK_HZ         = 8;
    localparam int unsigned TICK_CYCLES     = CLK_HZ / TICK_HZ;
    localparam int unsigned PHASE_S         = 15;
    localparam int unsigned PHASE_TICKS     = PHASE_S * TICK_HZ;
    localparam int unsigned SLOW_HALF_TICKS = 4;
    localparam int unsigned SLOW_FRAME      = 20;
    localparam int unsigned FAST_FRAME      = 16;

    // ---------------------------------------------------------------
    // Counts and widths
    // ---------------------------------------------------------------
    localparam int unsigned ID_W             = 32;
    localparam logic [3:0]  MAX_TAUGHT       = 4'h8;
    localparam logic [3:0]  INIT_FLASHES     = 4'h6;
    localparam logic [3:0]  AWAIT_FLASHES    = 4'h8;
    localparam logic [3:0]  FAULT_RED_FLASH  = 4'h3;
    localparam int unsigned INIT_TICKS       = 6 * 2 * SLOW_HALF_TICKS;

    typedef enum logic [3:0] {
        ST_INIT      = 4'h0,
        ST_AWAIT     = 4'h1,
        ST_PRESENT   = 4'h2,
        ST_VERIFY    = 4'h3,
        ST_PROGRAM   = 4'h4,
        ST_COMPLETE  = 4'h5,
        ST_PERM_ACK  = 4'h6,
        ST_PERM_DONE = 4'h7,
        ST_RUN       = 4'h8,
        ST_FAULT     = 4'h9
    } glt_state_t;

    typedef enum logic [2:0] {
        FLT_NONE      = 3'h0,
        FLT_UNIVERSAL = 3'h1,
        FLT_TAUGHT    = 3'h2,
        FLT_RANGE     = 3'h3,
        FLT_FULL      = 3'h4,
        FLT_PERM      = 3'h5
    } glt_fault_t;

    typedef struct packed {
        logic                       present;
        logic                       universal;
        logic [ID_W-1:0]            id;
    } glt_actuator_t;

    typedef struct packed {
        logic                       permanent;
        logic [3:0]                 count;
        logic [7:0][ID_W-1:0]       ids;
    } glt_nv_t;

endpackage

// [test/glt_nv_store.sv]
// Partner model: the non-volatile image store beside the controller.
// Assumes one write pulse carries a whole image; contents outlive reset.
`timescale 1ns/1ps
module glt_nv_store (
    input  wire logic             i_clock,
    input  wire logic             i_nv_write,
    input  wire glt_pkg::glt_nv_t i_image,
    output glt_pkg::glt_nv_t      o_image
);
    initial o_image = '0;
    // No reset here, storage must survive power cycles
    always @(posedge i_clock) begin
        if (i_nv_write)
            o_image <= i_image;
    end
endmodule

// [test/guard_lock_teach_in_controller_bench.sv]
// Self-checking bench of the guard lock teach-in controller.
// Assumes P_TICK_CYCLES of 4, so one tick is 16 ns and 15 s is 480 cycles.
`timescale 1ns/1ps
module guard_lock_teach_in_controller_bench;
    typedef struct packed {logic lk, pr, gd, cs, ft; logic [1:0] pair; logic eng;} glt_row_t;
    typedef struct packed {logic pm; logic [3:0] cnt; logic un, dr; logic [7:0] id;
        logic [2:0] code;} glt_flt_t;
    logic                   i_clock, i_arst_n, unq, guard, lock, casc, flt, wr, eng, grn, red;
    logic                   hi;
    logic [1:0]             pair;
    glt_pkg::glt_actuator_t act;
    glt_pkg::glt_nv_t       nv_in, nv_out;
    int                     err_count, tests_run, cyc, g, r, t0;
    glt_row_t               rows [6] = '{'{1,1,1,1,0,3,1}, '{0,1,1,1,0,0,0}, '{1,0,1,1,0,0,1},
                                         '{1,1,0,1,0,0,1}, '{1,1,1,0,0,0,1}, '{1,1,1,1,1,0,1}};
    glt_flt_t               flts [5] = '{'{0,0,1,0,8'hC0,1}, '{0,2,0,0,8'hA0,2},
                                         '{0,0,0,1,8'hC0,3}, '{0,8,0,0,8'hC0,4},
                                         '{1,1,0,0,8'hC0,5}};

    glt_controller #(.P_TICK_CYCLES(4)) dut (.i_clock(i_clock), .i_arst_n(i_arst_n),
        .i_variant_unique(unq), .i_guard_closed(guard), .i_actuator(act),
        .i_lock_command(lock), .i_cascade_inputs_on(casc), .i_internal_fault(flt),
        .i_nv_image(nv_in), .o_safety_output_pair(pair), .o_lock_engage(eng),
        .o_status_green(grn), .o_fault_indicator_red(red), .o_nv_write(wr),
        .o_nv_image(nv_out));
    glt_nv_store nv (.i_clock(i_clock), .i_nv_write(wr), .i_image(nv_out), .o_image(nv_in));

    initial begin
        i_clock = 0;
        forever #2 i_clock = ~i_clock;
    end

    // Cuts a hang short well past the expected run of about 4840 cycles
    always @(posedge i_clock) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            finish_test();
        end
    end

    // ---------------------------------------------------------------
    // Tasks
    // ---------------------------------------------------------------
    task automatic check(string n, logic [63:0] s, logic [63:0] e);
        tests_run++;
        if (s !== e) begin
            err_count++;
            $display("[ERR] %s expected %0h seen %0h", n, e, s);
        end
    endtask

    task automatic finish_test();
        $display("Checks %0d, errors %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Counts indicator rises and notes any safety output on
    task automatic watch(int n);
        logic pg, pr;
        g = 0;
        r = 0;
        hi = 0;
        pg = grn;
        pr = red;
        repeat (n) begin
            @(negedge i_clock);
            g += int'(grn === 1'b1 && pg === 1'b0);
            r += int'(red === 1'b1 && pr === 1'b0);
            hi |= (pair !== 2'h0);
            pg = grn;
            pr = red;
        end
    endtask

    task automatic wait_wr(int lim);
        t0 = 0;
        while (wr !== 1'b1 && t0 < lim) begin
            @(negedge i_clock);
            t0++;
        end
    endtask

    task automatic do_reset();
        i_arst_n = 0;
        repeat (2) @(negedge i_clock);
        check("reset outputs", {pair, eng, grn, red, wr}, 0);
        i_arst_n = 1;
    endtask

    // ---------------------------------------------------------------
    // Sequence
    // ---------------------------------------------------------------
    initial begin
        {err_count, tests_run, cyc} = 0;
        {unq, guard, lock, casc, flt} = 5'h12;
        act = '0;
        do_reset();
        watch(180);
        check("init flashes", g, 6);
        check("init outputs", hi, 0);
        watch(6);
        watch(310);
        check("await flashes", g, 8);
        act = '{1'b1, 1'b0, 32'hA0};
        guard = 1; // Held closed through teach
        watch(400);
        check("verify red", r >= 12, 1);
        wait_wr(1200);
        check("teach time", (400 + t0 >= 958) && (400 + t0 <= 966), 1);
        @(negedge i_clock);
        check("taught image", {nv_in.count, nv_in.ids[0]}, {4'h1, 32'hA0});
        watch(330);
        check("complete flashes", g, 7);
        guard = 0;
        repeat (4) @(negedge i_clock);
        watch(40);
        check("perm ack red", {red, r[3:0]}, 5'h10);
        guard = 1;
        wait_wr(100);
        check("perm write", wr, 1);
        @(negedge i_clock);
        check("perm flag", nv_in.permanent, 1);
        watch(64);
        check("perm green", g, 2);
        repeat (500) @(negedge i_clock);
        // Each row judges the output pair and the lock engage output
        foreach (rows[i]) begin
            {lock, act.present, guard, casc, flt} = rows[i][7:3];
            repeat (8) @(negedge i_clock);
            check("run pair", pair, rows[i].pair);
            check("run engage", eng, rows[i].eng);
        end
        watch(64);
        check("fault red 4 Hz", r, 8);
        {flt, act.present} = 2'b00;
        repeat (8) @(negedge i_clock);
        watch(64);
        check("absent green", g, 8);
        check("absent outputs", hi, 0);
        for (int k = 0; k < 8; k++) nv.o_image.ids[k] = 32'hA0 + k;
        foreach (flts[i]) begin
            {guard, lock, flt, act} = '0;
            nv.o_image.permanent = flts[i].pm;
            nv.o_image.count = flts[i].cnt;
            do_reset();
            repeat (200) @(negedge i_clock);
            act = '{1'b1, flts[i].un, {24'h0, flts[i].id}};
            guard = 1;
            if (flts[i].dr) begin
                repeat (100) @(negedge i_clock);
                act.present = 0;
            end
            repeat (40) @(negedge i_clock);
            watch(64);
            check("fault green", g, flts[i].code);
            check("fault red", {hi, r[3:0]}, 5'h03);
        end
        repeat (300) @(negedge i_clock);
        watch(64);
        check("fault held", g, 5);
        unq = 0;
        nv.o_image = '0;
        do_reset();
        act = '{1'b1, 1'b1, 32'hC0};
        {guard, lock, casc} = 3'h7;
        repeat (260) @(negedge i_clock);
        check("universal pair", pair, 2'h3);
        finish_test();
    end
endmodule
